// ==== ofr_pkg.sv ====
/*
  Package for the output frequency reconfiguration block: register map,
  field layouts, reset values, format codes and timing counts.
  Assumes an APB slave with 32-bit data and a 10 MHz pclk.
*/
package ofr_pkg;

  // Register byte offsets
  localparam logic [7:0] OFR_OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFR_OFF_FDINT   = 8'h04;
  localparam logic [7:0] OFR_OFF_FDNUM   = 8'h08;
  localparam logic [7:0] OFR_OFF_CHDIV   = 8'h0C;
  localparam logic [7:0] OFR_OFF_FMT     = 8'h10;
  localparam logic [7:0] OFR_OFF_STATUS  = 8'h14;
  localparam logic [7:0] OFR_OFF_RESOFS  = 8'h18;

  // CTRL fields
  localparam int OFR_CTRL_PWRDN_BIT  = 0;
  localparam int OFR_CTRL_OTPDIS_BIT = 1;
  localparam int OFR_CTRL_DIG_LSB    = 4;
  localparam int OFR_DIG_W           = 4;

  // Field widths
  localparam int OFR_INT_W  = 8;
  localparam int OFR_NUM_W  = 24;
  localparam int OFR_CH_W   = 3;
  localparam int OFR_REF_W  = 2;
  localparam int OFR_FMT_W  = 3;
  localparam int OFR_PIN_W  = 2;

  // CHDIV fields
  localparam int OFR_CH0_LSB = 0;
  localparam int OFR_REF_LSB = 4;
  localparam int OFR_SEL_BIT = 8;
  // FMT fields
  localparam int OFR_FMT0_LSB = 0;
  localparam int OFR_FMT1_LSB = 4;
  localparam int OFR_PIN_LSB  = 8;

  // Channel ratio codes: no divide-by-five code exists
  localparam logic [2:0] OFR_CH_DIV2 = 3'h0;
  localparam logic [2:0] OFR_CH_DIV4 = 3'h1;
  localparam logic [2:0] OFR_CH_DIV8 = 3'h2;
  localparam logic [2:0] OFR_CH_DIV6 = 3'h3;
  localparam logic [2:0] OFR_CH_DIV16 = 3'h4;
  // Reference ratio code /8
  localparam logic [1:0] OFR_REF_DIV8 = 2'h3;

  // Output format and pin function codes
  localparam logic [2:0] OFR_FMT_HCSL     = 3'h0;
  localparam logic [2:0] OFR_FMT_DIFFCMOS = 3'h4;
  localparam logic [1:0] OFR_PIN_REFCLK   = 2'h1;

  // Reset values
  localparam logic [7:0]  OFR_RST_INT  = 8'h18;
  localparam logic [23:0] OFR_RST_NUM  = 24'h000000;
  localparam logic [3:0]  OFR_RST_DIG  = 4'h2;
  localparam logic [15:0] OFR_RST_RESOFS = 16'h0000;

  // Divider output range in MHz (resonator base 2467 MHz)
  localparam int OFR_FDIV_MIN_MHZ = 100;
  localparam int OFR_FDIV_MAX_MHZ = 400;
  localparam int OFR_RES_MHZ     = 2467;

  // Restart time and cycle count at 10 MHz
  localparam int OFR_RESTART_US  = 1000;
  localparam int OFR_PCLK_MHZ    = 10;
  localparam int OFR_RESTART_CYC = OFR_RESTART_US * OFR_PCLK_MHZ;

  // Active divider settings, applied as one group
  typedef struct packed {
    logic [7:0]  fd_int;
    logic [23:0] fd_num;
    logic [2:0]  ch0_ratio;
    logic [1:0]  ref_ratio;
    logic        out1_sel;
    logic [2:0]  fmt0;
    logic [2:0]  fmt1;
    logic [1:0]  pin_func;
    logic [3:0]  dig_ratio;
  } ofr_cfg_t;

endpackage

// ==== ofr_restart_timer.sv ====
/*
  Restart timer: counts the output restart delay after power-down release.
  Assumes start is a one-cycle pulse on pclk.
*/
`timescale 1ns/10ps
module ofr_restart_timer #(
  parameter int CYCLES = ofr_pkg::OFR_RESTART_CYC
) (
  input  wire logic pclk,     // Clock
  input  wire logic presetn,  // Async reset, low
  input  wire logic abort,    // Cancel count
  input  wire logic start,    // Begin count
  output logic      busy,     // Counting
  output logic      done      // One-cycle end pulse
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_q, cnt_d;
  logic          done_q, done_d;

  initial begin
    if (CYCLES < 1) $error("CYCLES must be at least 1");
  end

  // Down counter, done fires when it reaches zero
  // Start wins over abort: the release edge still sees abort high
  always_comb begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (start) begin
      cnt_d = CW'(CYCLES);
    end else if (abort) begin
      cnt_d = '0;
    end else if (cnt_q != '0) begin
      cnt_d  = cnt_q - CW'(1);
      done_d = (cnt_q == CW'(1));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign busy = (cnt_q != '0);
  assign done = done_q;
endmodule // ofr_restart_timer

// ==== ofr_core.sv ====
/*
  Output frequency reconfiguration core: APB register file, power-down
  gated settings and output restart sequence.
  Assumes a 10 MHz pclk and an APB master; analog clocks are outside.
*/
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/10ps
module ofr_core #(
  parameter int RESTART_CYC = ofr_pkg::OFR_RESTART_CYC
) (
  input  wire logic        pclk,          // APB clock
  input  wire logic        presetn,       // Async reset, low
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB enable
  input  wire logic        pwrite,        // APB direction
  input  wire logic [7:0]  paddr,         // APB address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic      [31:0] prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error
  output ofr_pkg::ofr_cfg_t active_cfg,   // Settings in force
  output logic             outputs_on,    // Output drivers enabled
  output logic             otp_autoload_en // Autoload of OTP page 0
);
  logic              pwr_down_q, pwr_down_d;
  logic              otpdis_q, otpdis_d;
  ofr_pkg::ofr_cfg_t shadow_q, shadow_d;
  ofr_pkg::ofr_cfg_t act_q, act_d;
  logic              on_q, on_d;
  logic              rej_q, rej_d;
  logic [31:0]       rdata;
  logic              wr, rd, bad, t_busy, t_done, release_pwr_down;
  logic [11:0]       fdiv_mhz;
  logic [4:0]        sm_div;

  typedef enum logic [1:0] {OFR_RUN, OFR_HELD, OFR_START} ofr_state_t;
  ofr_state_t st_q, st_d;

  initial begin
    if (RESTART_CYC < 1) $error("RESTART_CYC must be at least 1");
  end

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;

  // Decode; unmapped addresses answer with pslverr
  always_comb begin
    case (paddr)
      ofr_pkg::OFR_OFF_CTRL, ofr_pkg::OFR_OFF_FDINT, ofr_pkg::OFR_OFF_FDNUM,
      ofr_pkg::OFR_OFF_CHDIV, ofr_pkg::OFR_OFF_FMT, ofr_pkg::OFR_OFF_STATUS,
      ofr_pkg::OFR_OFF_RESOFS: bad = 1'b0;
      default: bad = 1'b1;
    endcase
  end

  // Approximate divider output from the integer field
  assign fdiv_mhz = (shadow_q.fd_int == 8'h00) ? 12'hFFF :
                    12'(ofr_pkg::OFR_RES_MHZ / shadow_q.fd_int);

  // Setting writes land in the shadow set only; the CTRL power-down and OTP disable bits take effect at once
  always_comb begin
    pwr_down_d = pwr_down_q;
    otpdis_d   = otpdis_q;
    shadow_d   = shadow_q;
    if (wr) begin
      case (paddr)
        ofr_pkg::OFR_OFF_CTRL: begin
          pwr_down_d = pwdata[ofr_pkg::OFR_CTRL_PWRDN_BIT];
          otpdis_d = otpdis_q | pwdata[ofr_pkg::OFR_CTRL_OTPDIS_BIT];
          if (pwr_down_q) begin
            shadow_d.dig_ratio =
              pwdata[ofr_pkg::OFR_CTRL_DIG_LSB +: ofr_pkg::OFR_DIG_W];
          end
        end
        ofr_pkg::OFR_OFF_FDINT: shadow_d.fd_int = pwdata[7:0];
        ofr_pkg::OFR_OFF_FDNUM: shadow_d.fd_num = pwdata[23:0];
        ofr_pkg::OFR_OFF_CHDIV: begin
          // Ratio code five and above is refused and kept as before
          if (pwdata[ofr_pkg::OFR_CH0_LSB +: ofr_pkg::OFR_CH_W] <=
              ofr_pkg::OFR_CH_DIV16) begin
            shadow_d.ch0_ratio =
              pwdata[ofr_pkg::OFR_CH0_LSB +: ofr_pkg::OFR_CH_W];
          end
          shadow_d.ref_ratio =
            pwdata[ofr_pkg::OFR_REF_LSB +: ofr_pkg::OFR_REF_W];
          shadow_d.out1_sel = pwdata[ofr_pkg::OFR_SEL_BIT];
        end
        ofr_pkg::OFR_OFF_FMT: begin
          shadow_d.fmt0     = pwdata[ofr_pkg::OFR_FMT0_LSB +:
                                     ofr_pkg::OFR_FMT_W];
          shadow_d.fmt1     = pwdata[ofr_pkg::OFR_FMT1_LSB +:
                                     ofr_pkg::OFR_FMT_W];
          shadow_d.pin_func = pwdata[ofr_pkg::OFR_PIN_LSB +:
                                     ofr_pkg::OFR_PIN_W];
        end
        default: ;
      endcase
    end
  end

  assign release_pwr_down = pwr_down_q && !pwr_down_d;

  // Sequencer: settings apply only at release, range checked
  always_comb begin
    st_d  = st_q;
    act_d = act_q;
    on_d  = on_q;
    rej_d = rej_q;
    case (st_q)
      OFR_RUN: if (pwr_down_q) begin
        st_d = OFR_HELD;
        on_d = 1'b0;
      end
      OFR_HELD: if (release_pwr_down) begin
        if (fdiv_mhz >= 12'(ofr_pkg::OFR_FDIV_MIN_MHZ) &&
            fdiv_mhz <= 12'(ofr_pkg::OFR_FDIV_MAX_MHZ)) begin
          act_d = shadow_q;
          rej_d = 1'b0;
        end else begin
          rej_d = 1'b1;
        end
        st_d = OFR_START;
      end
      OFR_START: if (pwr_down_q) begin
        st_d = OFR_HELD;
      end else if (t_done) begin
        on_d = 1'b1;
        st_d = OFR_RUN;
      end
      default: st_d = OFR_RUN;
    endcase
  end

  ofr_restart_timer #(.CYCLES(RESTART_CYC)) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .abort   (pwr_down_q),
    .start   (release_pwr_down),
    .busy    (t_busy),
    .done    (t_done)
  );

  // State clock divisor seen by the analog side: two plus the ratio field
  assign sm_div = 5'h02 + {1'b0, act_q.dig_ratio};

  // Read mux
  always_comb begin
    rdata = 32'h00000000;
    if (rd) begin
      case (paddr)
        ofr_pkg::OFR_OFF_CTRL: rdata = {24'h000000, shadow_q.dig_ratio,
                                        2'b00, otpdis_q, pwr_down_q};
        ofr_pkg::OFR_OFF_FDINT: rdata = {24'h000000, shadow_q.fd_int};
        ofr_pkg::OFR_OFF_FDNUM: rdata = {8'h00, shadow_q.fd_num};
        ofr_pkg::OFR_OFF_CHDIV: rdata = {23'h000000, shadow_q.out1_sel,
                                         2'b00, shadow_q.ref_ratio,
                                         1'b0, shadow_q.ch0_ratio};
        ofr_pkg::OFR_OFF_FMT: rdata = {22'h000000, shadow_q.pin_func,
                                       1'b0, shadow_q.fmt1,
                                       1'b0, shadow_q.fmt0};
        // Divisor in [8:4] lets software confirm the state clock setting
        ofr_pkg::OFR_OFF_STATUS: rdata = {23'h000000, sm_div, rej_q, t_busy,
                                          (st_q == OFR_HELD), on_q};
        ofr_pkg::OFR_OFF_RESOFS: rdata = {16'h0000, ofr_pkg::OFR_RST_RESOFS};
        default: rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_down_q         <= 1'b0;
      otpdis_q           <= 1'b0;
      shadow_q           <= '0;
      shadow_q.fd_int    <= ofr_pkg::OFR_RST_INT;
      shadow_q.fd_num    <= ofr_pkg::OFR_RST_NUM;
      shadow_q.ch0_ratio <= ofr_pkg::OFR_CH_DIV2;
      shadow_q.out1_sel  <= 1'b0;
      shadow_q.fmt0      <= ofr_pkg::OFR_FMT_HCSL;
      shadow_q.fmt1      <= ofr_pkg::OFR_FMT_HCSL;
      shadow_q.dig_ratio <= ofr_pkg::OFR_RST_DIG;
      act_q              <= '0;
      act_q.fd_int       <= ofr_pkg::OFR_RST_INT;
      act_q.fd_num       <= ofr_pkg::OFR_RST_NUM;
      act_q.ch0_ratio    <= ofr_pkg::OFR_CH_DIV2;
      act_q.out1_sel     <= 1'b0;
      act_q.fmt0         <= ofr_pkg::OFR_FMT_HCSL;
      act_q.fmt1         <= ofr_pkg::OFR_FMT_HCSL;
      act_q.dig_ratio    <= ofr_pkg::OFR_RST_DIG;
      on_q               <= 1'b1;
      rej_q              <= 1'b0;
      st_q               <= OFR_RUN;
    end else begin
      pwr_down_q <= pwr_down_d;
      otpdis_q <= otpdis_d;
      shadow_q <= shadow_d;
      act_q    <= act_d;
      on_q     <= on_d;
      rej_q    <= rej_d;
      st_q     <= st_d;
    end
  end

  // Zero-wait slave; data and error come from the same access edge
  assign pready          = 1'b1;
  assign prdata          = rdata;
  assign pslverr         = psel && penable && bad;
  assign active_cfg      = act_q;
  assign outputs_on      = on_q && !pwr_down_q;
  assign otp_autoload_en = !otpdis_q;

  // Drivers off while held, and the sequencer keeps them off next cycle
  property p_pwr_down_off;
    @(posedge pclk) disable iff (!presetn)
      pwr_down_q |-> !outputs_on ##1 !on_q;
  endproperty
  a_pwr_down_off: assert property (p_pwr_down_off)
    else $error("outputs on in power down");

  property p_hold_cfg;
    @(posedge pclk) disable iff (!presetn)
      pwr_down_q && $past(pwr_down_q) |-> $stable(active_cfg);
  endproperty
  a_hold_cfg: assert property (p_hold_cfg)
    else $error("cfg moved in power down");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
      $fell(pwr_down_q) |-> !outputs_on [*8];
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart too early");

  property p_no_div5;
    @(posedge pclk) disable iff (!presetn)
      shadow_q.ch0_ratio <= ofr_pkg::OFR_CH_DIV16;
  endproperty
  a_no_div5: assert property (p_no_div5)
    else $error("bad channel ratio");

  property p_otp_sticky;
    @(posedge pclk) disable iff (!presetn)
      wr && paddr == ofr_pkg::OFR_OFF_CTRL &&
      pwdata[ofr_pkg::OFR_CTRL_OTPDIS_BIT] |=> !otp_autoload_en;
  endproperty
  a_otp_sticky: assert property (p_otp_sticky)
    else $error("otp still on");

  property p_dig_held;
    @(posedge pclk) disable iff (!presetn)
      !pwr_down_q |=> $stable(shadow_q.dig_ratio);
  endproperty
  a_dig_held: assert property (p_dig_held)
    else $error("ratio written live");

  // Either side of the window must leave the reject flag set
  property p_range;
    @(posedge pclk) disable iff (!presetn)
      st_q == OFR_HELD && release_pwr_down &&
      (fdiv_mhz > 12'(ofr_pkg::OFR_FDIV_MAX_MHZ) ||
       fdiv_mhz < 12'(ofr_pkg::OFR_FDIV_MIN_MHZ)) |=> rej_q;
  endproperty
  a_range: assert property (p_range)
    else $error("range not refused");

  property p_sel_reset;
    @(posedge pclk) $rose(presetn) |-> !active_cfg.out1_sel;
  endproperty
  a_sel_reset: assert property (p_sel_reset)
    else $error("sel not ch0");
endmodule // ofr_core

// ==== ofr_host_model.sv ====
/*
  Host model: an APB master that programs the reconfiguration registers.
  Assumes one pclk and a slave that may stretch its access phase.
*/
`timescale 1ns/10ps
module ofr_host_model (
  input  wire logic        pclk,     // Clock
  output logic             psel,     // Select
  output logic             penable,  // Access phase
  output logic             pwrite,   // Direction
  output logic      [7:0]  paddr,    // Byte address
  output logic      [31:0] pwdata,   // Write data
  input  wire logic [31:0] prdata,   // Read data
  input  wire logic        pready,   // Ready
  input  wire logic        pslverr   // Error
);
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // One transfer; request held until pready seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Write, discarding the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    xfer(1'b1, a, d, rd, err);
  endtask

  // Power down first, then dividers, formats, pin and state ratio
  task automatic setup(input logic [31:0] fint, input logic [31:0] fnum,
                       input logic [31:0] chdiv, input logic [31:0] fmt);
    wr(ofr_pkg::OFR_OFF_CTRL, 32'h00000001);
    wr(ofr_pkg::OFR_OFF_FDINT, fint);
    wr(ofr_pkg::OFR_OFF_FDNUM, fnum);
    wr(ofr_pkg::OFR_OFF_CHDIV, chdiv);
    wr(ofr_pkg::OFR_OFF_FMT, fmt);
    wr(ofr_pkg::OFR_OFF_CTRL, 32'h00000023);
  endtask

  // Release power down only after every setting is written
  task automatic release_pd();
    wr(ofr_pkg::OFR_OFF_CTRL, 32'h00000022);
  endtask
endmodule // ofr_host_model

// ==== output_freq_reconfig_tb.sv ====
/*
  Testbench for the reconfiguration core: reset state, a full frequency
  change, refused settings and unmapped access.
  Assumes the host model above and a shortened restart count.
*/
`timescale 1ns/10ps
module output_freq_reconfig_tb;
  localparam int RC = 20;  // Short restart count keeps runs brief

  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  ofr_pkg::ofr_cfg_t active_cfg;
  logic              outputs_on;
  logic              otp_autoload_en;
  int                failures;
  int                n_tests;
  int                n;
  int                exp_int;
  int                exp_num;
  real               fres;
  logic [31:0]       rd;
  logic              err;

  ofr_core #(.RESTART_CYC(RC)) ofr_core_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .active_cfg(active_cfg),
    .outputs_on(outputs_on), .otp_autoload_en(otp_autoload_en)
  );

  ofr_host_model ofr_host_model_i (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr)
  );

  // 100 ns clock
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_sim();
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Cycles until drivers come back, capped so a hang cannot stall us
  task automatic wait_on(output int cnt);
    cnt = 0;
    while (outputs_on !== 1'b1 && cnt < 200) begin
      @(posedge pclk);
      cnt++;
    end
  endtask

  // Hang guard, well beyond the 150 or so cycles needed
  initial begin
    #500000;
    failures++;
    end_sim();
  end

  // Main sequence
  initial begin
    failures = 0;
    n_tests = 0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'(active_cfg.fd_int), 32'(ofr_pkg::OFR_RST_INT));
    check(32'(active_cfg.ch0_ratio), 32'h0);
    check(32'(active_cfg.out1_sel), 32'h0);
    check(32'(active_cfg.dig_ratio), 32'(ofr_pkg::OFR_RST_DIG));
    check(32'(otp_autoload_en), 32'h1);
    check(32'(outputs_on), 32'h1);
    // Divider values for a 192 MHz target from the trimmed resonator
    fres = 2471.446441856;
    exp_int = $rtoi(fres / 192.0);
    exp_num = $rtoi((fres / 192.0 - exp_int) * 16777216.0);
    check(32'(exp_int), 32'd12);
    check(32'(exp_num), 32'd14631693);
    ofr_host_model_i.setup(32'(exp_int), 32'(exp_num), 32'h32, 32'h144);
    ofr_host_model_i.wr(ofr_pkg::OFR_OFF_CHDIV, 32'h35);
    @(posedge pclk);
    check(32'(outputs_on), 32'h0);
    check(32'(active_cfg.fd_int), 32'(ofr_pkg::OFR_RST_INT));
    ofr_host_model_i.release_pd();
    wait_on(n);
    check(32'(n >= RC && n <= RC + 4), 32'h1);
    check(32'(active_cfg.fd_int), 32'd12);
    check(32'(active_cfg.fd_num), 32'd14631693);
    check(32'(active_cfg.ch0_ratio), 32'(ofr_pkg::OFR_CH_DIV8));
    check(32'(active_cfg.ref_ratio), 32'(ofr_pkg::OFR_REF_DIV8));
    check(32'(active_cfg.fmt0), 32'(ofr_pkg::OFR_FMT_DIFFCMOS));
    check(32'(active_cfg.fmt1), 32'(ofr_pkg::OFR_FMT_DIFFCMOS));
    check(32'(active_cfg.pin_func), 32'(ofr_pkg::OFR_PIN_REFCLK));
    check(32'(active_cfg.dig_ratio), 32'h2);
    check(32'(otp_autoload_en), 32'h0);
    // State clock divisor is two plus the ratio field: 192 / 4 = 48 MHz
    ofr_host_model_i.xfer(1'b0, ofr_pkg::OFR_OFF_STATUS, 32'h0, rd, err);
    check((rd >> 4) & 32'h1F, 32'h4);
    check(rd & 32'h1, 32'h1);
    // Ratio write with power down clear must not land
    ofr_host_model_i.wr(ofr_pkg::OFR_OFF_CTRL, 32'h52);
    wait_on(n);
    check(32'(active_cfg.dig_ratio), 32'h2);
    ofr_host_model_i.xfer(1'b0, ofr_pkg::OFR_OFF_CTRL, 32'h0, rd, err);
    check(rd, 32'h22);
    // Integers for 82, 205 and 493 MHz: the outer two are refused
    for (int i = 0; i < 3; i++) begin
      ofr_host_model_i.setup(i == 0 ? 32'h1E : (i == 1 ? 32'h0C : 32'h05),
                             32'h0, 32'h32, 32'h144);
      ofr_host_model_i.release_pd();
      @(posedge pclk);
      @(posedge pclk);
      check(32'(active_cfg.fd_int), 32'd12);
      ofr_host_model_i.xfer(1'b0, ofr_pkg::OFR_OFF_STATUS, 32'h0, rd, err);
      check(rd & 32'h8, (i == 1) ? 32'h0 : 32'h8);
    end
    // Unmapped and read-only places
    ofr_host_model_i.xfer(1'b0, 8'h1C, 32'h0, rd, err);
    check(32'(err), 32'h1);
    check(rd, 32'h0);
    ofr_host_model_i.wr(ofr_pkg::OFR_OFF_RESOFS, 32'h3701);
    ofr_host_model_i.xfer(1'b0, ofr_pkg::OFR_OFF_RESOFS, 32'h0, rd, err);
    check(rd, 32'(ofr_pkg::OFR_RST_RESOFS));
    end_sim();
  end
endmodule // output_freq_reconfig_tb
